/* File: dv/cnrst_core_assertions.sv */
`timescale 1ns/1ps
`include "cnrst_defs.vh"
// ****************
// Port checker
// ****************
module cnrst_core_chk #(
  parameter NMB = 16,
  parameter IDW = 29
) (
  input wire clk_sys,
  input wire nrst,
  input wire lowpwr_req,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire can_rx,
  input wire link_busy,
  input wire tx_done,
  input wire err_tx,
  input wire err_rx,
  input wire tx_load,
  input wire [3:0] tx_mb,
  input wire [IDW-1:0] tx_id,
  input wire bus_on,
  input wire [NMB-1:0] mb_dir,
  input wire reset_state_bit
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  rst_vals_a: assert property ($rose(nrst) |-> mb_dir[0] && reset_state_bit)
    else $error("reset values wrong");
  mb0_recv_a: assert property (mb_dir[0])
    else $error("mailbox 0 not receive");
  dir_write_a: assert property (wr && addr == `CNRST_A_DIR
    |=> {16'h0, mb_dir} == ($past(wdata) & 32'h0000ffff | 32'h00000001))
    else $error("direction write lost");
  cfg_quiet_a: assert property (reset_state_bit && $past(reset_state_bit, 3)
    |-> !bus_on && !tx_load)
    else $error("traffic in configuration");
  load_dir_a: assert property (tx_load |-> tx_mb != 4'h0 && !mb_dir[tx_mb])
    else $error("receiver loaded for send");
  load_gap_a: assert property (tx_load |=> !tx_load)
    else $error("back to back load");
  leave_delay_a: assert property (wr && addr == `CNRST_A_CTRL && !wdata[0]
    && reset_state_bit && !lowpwr_req |-> ##[1:8] !reset_state_bit)
    else $error("configuration not left");
  lowpwr_reset_a: assert property ($rose(lowpwr_req) && !link_busy
    |-> ##[0:10] reset_state_bit)
    else $error("low power reset missing");
  bus_late_a: assert property ($rose(bus_on) |-> !$past(reset_state_bit, 20))
    else $error("bus on too early");
endmodule
bind cnrst_core cnrst_core_chk #(.NMB(NMB), .IDW(IDW)) cnrst_core_chk_inst (
  .clk_sys(clk_sys), .nrst(nrst), .lowpwr_req(lowpwr_req), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .can_rx(can_rx),
  .link_busy(link_busy), .tx_done(tx_done), .err_tx(err_tx), .err_rx(err_rx),
  .tx_load(tx_load), .tx_mb(tx_mb), .tx_id(tx_id), .bus_on(bus_on),
  .mb_dir(mb_dir), .reset_state_bit(reset_state_bit)
);

/* File: dv/cnrst_link_model.sv */
`timescale 1ns/1ps
// ****************
// Bus side model
// ****************
module cnrst_link_model (
  input wire clk_sys,
  input wire nrst,
  input wire tx_load,
  input wire slow,
  input wire hold,
  output wire can_rx,
  output reg link_busy,
  output reg tx_done
);
  reg [7:0] cnt;
  // Wired bus pulled high, so idle reads recessive
  assign can_rx = 1'b1;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= 8'h00;
      link_busy <= 1'b0;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (tx_load) begin
        cnt <= slow ? 8'h28 : 8'h06;
        link_busy <= 1'b1;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
        tx_done <= (cnt == 8'h01);
      end else begin
        // Another node's frame keeps the link busy
        link_busy <= hold;
      end
    end
  end
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
`include "cnrst_defs.vh"
// ****************
// Testbench
// ****************
module testbench;
  reg clk_sys = 1'b0;
  reg nrst = 1'b0;
  reg lowpwr_req = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg err_tx = 1'b0;
  reg err_rx = 1'b0;
  reg slow = 1'b0;
  reg hold = 1'b0;
  wire [31:0] rdata;
  wire can_rx, link_busy, tx_done, tx_load, bus_on, reset_state_bit;
  wire [3:0] tx_mb;
  wire [28:0] tx_id;
  wire [15:0] mb_dir;
  integer num_errors = 0;
  integer cmp_count = 0;
  integer i, k, n, t, bitc;
  reg [28:0] ids [0:15];
  reg [15:0] dirv, m, rem;
  reg [31:0] bcfg, dv;
  integer got [$];
  integer gid [$];
  integer expq [$];
  // Reset table: index and value, first entry on the left
  localparam [27:0] RA = 28'h012347f;
  localparam [27:0] RV = 28'h1810100;
  always #20 clk_sys = ~clk_sys;
  cnrst_core cnrst_core_inst (
    .clk_sys(clk_sys), .nrst(nrst), .lowpwr_req(lowpwr_req), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .can_rx(can_rx),
    .link_busy(link_busy), .tx_done(tx_done), .err_tx(err_tx), .err_rx(err_rx),
    .tx_load(tx_load), .tx_mb(tx_mb), .tx_id(tx_id), .bus_on(bus_on),
    .mb_dir(mb_dir), .reset_state_bit(reset_state_bit));
  cnrst_link_model cnrst_link_model_inst (
    .clk_sys(clk_sys), .nrst(nrst), .tx_load(tx_load), .slow(slow), .hold(hold),
    .can_rx(can_rx), .link_busy(link_busy), .tx_done(tx_done));
  always @(posedge clk_sys) begin
    if (tx_load === 1'b1) begin
      got.push_back(tx_mb);
      gid.push_back(tx_id);
    end
  end
  task check(input string nm, input [31:0] seen, input [31:0] ev);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== ev) begin
        num_errors = num_errors + 1;
        $display("unexpected %s expected %h seen %h", nm, ev, seen);
      end
    end
  endtask
  task final_report;
    begin
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask
  task wreg(input [3:0] a, input [31:0] d);
    begin
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
    end
  endtask
  task rchk(input string nm, input [3:0] a, input [31:0] ev);
    begin
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(posedge clk_sys);
      check(nm, rdata, ev);
    end
  endtask
  task leave_cfg;
    begin
      wreg(`CNRST_A_CTRL, 32'h0);
      t = 0;
      while (bus_on !== 1'b1 && t < 4000) begin
        @(posedge clk_sys);
        t = t + 1;
      end
      check("state bit", reset_state_bit, 0);
      check("bus on delay", t >= 10 * bitc && t <= 12 * bitc + 20, 1);
    end
  endtask
  task tx_run(input integer mode);
    begin
      got.delete();
      gid.delete();
      expq.delete();
      slow <= (mode == 1);
      wreg(`CNRST_A_ACK, 32'hffff);
      wreg(`CNRST_A_CTRL, mode << 2);
      m = (16'h0002 | $urandom) & ~dirv & 16'hfffe;
      rem = m;
      n = $countones(m);
      for (k = 0; k < n; k = k + 1) begin
        t = -1;
        for (i = 1; i < 16; i = i + 1) begin
          if (rem[i] && (t < 0 || (mode == 0 && ids[i] < ids[t]))) t = i;
        end
        rem[t] = 1'b0;
        expq.push_back(t);
      end
      wreg(`CNRST_A_PEND, m);
      t = 0;
      while ((got.size() < n || link_busy !== 1'b0) && t < 3000) begin
        @(posedge clk_sys);
        t = t + 1;
      end
      repeat (3) @(posedge clk_sys);
      check("load count", got.size(), n);
      for (k = 0; k < n && k < got.size(); k = k + 1) begin
        check("tx mailbox", got[k], expq[k]);
        check("tx identifier", gid[k], ids[expq[k]]);
      end
      rchk("pending", `CNRST_A_PEND, 32'h0);
      rchk("acknowledge", `CNRST_A_ACK, m);
    end
  endtask
  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors = num_errors + 1;
    final_report;
  end
  initial begin
    void'($urandom(8108));
    repeat (10) @(posedge clk_sys);
    check("state port", reset_state_bit, 1);
    nrst <= 1'b1;
    for (i = 0; i < 7; i = i + 1) rchk("reset value", RA[24-4*i +: 4], RV[24-4*i +: 4]);
    wreg(`CNRST_A_IFLG, 32'h1);
    rchk("reset flag", `CNRST_A_IFLG, 32'h0);
    dirv = ($urandom & 16'h5554) | 16'h0001;
    wreg(`CNRST_A_DIR, dirv & 16'hfffe);
    rchk("direction", `CNRST_A_DIR, dirv);
    check("direction port", mb_dir, dirv);
    k = 1 + $urandom % 3;
    bcfg = ((1 + $urandom % 3) << 8) | (k << 4) | (k + 2 + $urandom % 4);
    bitc = 2 * (bcfg[13:8] + 1) * (3 + bcfg[3:0] + bcfg[6:4]);
    wreg(`CNRST_A_BITCFG, bcfg);
    rchk("bit config", `CNRST_A_BITCFG, bcfg);
    for (i = 1; i < 16; i = i + 1) begin
      ids[i] = dirv[i] ? i : $urandom;
      wreg(`CNRST_A_MBSEL, i);
      wreg(`CNRST_A_MBID, ids[i]);
    end
    dv = $urandom;
    for (k = 0; k < 4; k = k + 1) wreg(`CNRST_A_MBDATA, (k << 8) | dv[8*k +: 8]);
    rchk("payload", `CNRST_A_MBDATA, dv);
    leave_cfg;
    for (k = 0; k < 3; k = k + 1) begin
      @(posedge clk_sys);
      err_tx <= 1'b1;
      err_rx <= (k < 2);
      @(posedge clk_sys);
      err_tx <= 1'b0;
      err_rx <= 1'b0;
    end
    rchk("error counts", `CNRST_A_ERRCNT, 32'h0203);
    // Frame in progress must hold off the software reset
    hold <= 1'b1;
    wreg(`CNRST_A_CTRL, 32'h1);
    repeat (20) @(posedge clk_sys);
    check("state in frame", reset_state_bit, 0);
    hold <= 1'b0;
    t = 0;
    while (reset_state_bit !== 1'b1 && t < 100) begin
      @(posedge clk_sys);
      t = t + 1;
    end
    check("state after frame", reset_state_bit, 1);
    rchk("error counts", `CNRST_A_ERRCNT, 32'h0);
    rchk("direction", `CNRST_A_DIR, dirv);
    rchk("bit config", `CNRST_A_BITCFG, bcfg);
    leave_cfg;
    tx_run(0);
    tx_run(1);
    @(posedge clk_sys);
    lowpwr_req <= 1'b1;
    repeat (12) @(posedge clk_sys);
    lowpwr_req <= 1'b0;
    check("state low power", reset_state_bit, 1);
    rchk("reset flag", `CNRST_A_IFLG, 32'h1);
    nrst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rchk("direction", `CNRST_A_DIR, 32'h1);
    wreg(`CNRST_A_MBSEL, 32'hf);
    rchk("payload kept", `CNRST_A_MBDATA, dv);
    final_report;
  end
endmodule

/* File: verilog/cnrst_bit_timer.v */
`timescale 1ns/1ps
`include "cnrst_defs.vh"
// ****************
// Bit timer
// ****************
module cnrst_bit_timer (
  input wire clk_sys,
  input wire nrst,
  input wire run,
  input wire tq_tick,
  input wire [3:0] seg_one,
  input wire [2:0] seg_two,
  input wire [1:0] jump,
  input wire rx_edge,
  output reg sample_pulse,
  output reg bit_end
);
  reg [4:0] tq_cnt;
  reg [4:0] limit;
  reg [4:0] next_limit;
  wire [4:0] nominal = `CNRST_BIT_BASE + {1'b0, seg_one} + {2'b00, seg_two};
  wire [4:0] sample_at = 5'h01 + {1'b0, seg_one} + 5'h01;
  wire [4:0] jw = {3'b000, jump} + 5'h01;
  always @* begin
    next_limit = limit;
    // Late edge stretches phase one, early edge trims phase two
    if (rx_edge && tq_cnt != 5'h00) begin
      if (tq_cnt < sample_at) begin
        next_limit = nominal + ((tq_cnt < jw) ? tq_cnt : jw);
      end else begin
        next_limit = nominal - jw;
      end
    end
  end
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tq_cnt <= 5'h00;
      limit <= 5'h00;
      sample_pulse <= 1'b0;
      bit_end <= 1'b0;
    end else if (!run) begin
      tq_cnt <= 5'h00;
      limit <= nominal;
      sample_pulse <= 1'b0;
      bit_end <= 1'b0;
    end else if (tq_tick) begin
      sample_pulse <= (tq_cnt == sample_at - 5'h01);
      if (tq_cnt + 5'h01 >= next_limit) begin
        tq_cnt <= 5'h00;
        limit <= nominal;
        bit_end <= 1'b1;
      end else begin
        tq_cnt <= tq_cnt + 5'h01;
        limit <= next_limit;
        bit_end <= 1'b0;
      end
    end else begin
      sample_pulse <= 1'b0;
      bit_end <= 1'b0;
      limit <= next_limit;
    end
  end
endmodule

/* File: verilog/cnrst_core.v */
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "cnrst_defs.vh"
// Notes on behaviour
// - Sixteen mailboxes, each with eight byte-wide payload locations.
// - Hardware reset or low-power entry sets reset request and reset state.
// - Hardware reset clears registers but leaves mailbox storage intact.
// - Software reset clears only the two error counters.
// - Software reset waits for any frame in progress to finish.
// - Reset state bit sets on entry to the configuration state; hardware reset sets it at once.
// - Clearing reset request leaves configuration; state bit clears after a delay.
// - Bus traffic starts only after eleven recessive bits.
// - Reset interrupt flag set after power-on and low-power entry; software clears.
// - Time quantum is two clocks times prescaler plus one.
// - A bit lasts three plus segment one plus segment two quanta.
// - Each segment lasts its field value plus one quanta.
// - Resync lengthens phase one or shortens phase two.
// - Mailbox 0 receive only; others selectable, transmit after reset.
// - Direction settings survive a software reset.
// - Direction bit 0 means transmit, 1 means receive.
// - Order select picks identifier priority or mailbox number.
// - Identifier mode loads the highest-priority pending message.
// - Number mode loads pending messages in ascending mailbox order.
// - Pending bit waits; good transmission sets acknowledge, clears pending.
module cnrst_core #(
  parameter NMB = 16,
  parameter IDW = 29
) (
  input wire clk_sys,
  input wire nrst,
  input wire lowpwr_req,
  input wire [3:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  input wire can_rx,
  input wire link_busy,
  input wire tx_done,
  input wire err_tx,
  input wire err_rx,
  output reg tx_load,
  output reg [3:0] tx_mb,
  output reg [IDW-1:0] tx_id,
  output reg bus_on,
  output reg [NMB-1:0] mb_dir,
  output reg reset_state_bit
);
  // ****************
  // Control state
  // ****************
  localparam S_CFG = 2'b00;
  localparam S_LEAVE = 2'b01;
  localparam S_IDLE = 2'b10;
  localparam S_RUN = 2'b11;
  reg [1:0] state;
  reg [1:0] next_state;
  reg reset_request_bit;
  reg tx_order_select;
  reg reset_interrupt_flag;
  reg [15:0] bit_configuration_register;
  reg [NMB-1:0] transmit_pending;
  reg [NMB-1:0] tx_ack;
  reg [7:0] transmit_error_counter;
  reg [7:0] receive_error_counter;
  reg [3:0] mb_sel;
  reg [3:0] dly;
  reg [3:0] idle_cnt;
  reg rx_q;
  reg in_flight;
  reg [3:0] sel_mb;
  reg sel_found;
  reg [IDW-1:0] sel_id;
  integer k;
  // ****************
  // Mailbox storage
  // ****************
  // No reset on storage: contents persist over every reset
  reg [IDW-1:0] mb_id [0:NMB-1];
  reg [63:0] message_payload_bytes [0:NMB-1];
  wire [2:0] byte_sel = wdata[10:8];
  genvar g;
  generate
    for (g = 0; g < NMB; g = g + 1) begin : g_mb
      always @(posedge clk_sys) begin
        if (wr && mb_sel == g && addr == `CNRST_A_MBID) begin
          mb_id[g] <= wdata[IDW-1:0];
        end
        if (wr && mb_sel == g && addr == `CNRST_A_MBDATA) begin
          message_payload_bytes[g][byte_sel*8 +: 8] <= wdata[7:0];
        end
      end
    end
  endgenerate
  // ****************
  // Timing
  // ****************
  wire tq_tick;
  wire sample_pulse;
  wire bit_end;
  wire timing_run = (state == S_IDLE) || (state == S_RUN);
  cnrst_tq_gen #(
    .PW(6)
  ) u_tq (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(timing_run),
    .prescaler(bit_configuration_register[`CNRST_BRP_HI:`CNRST_BRP_LO]),
    .tq_tick(tq_tick)
  );
  cnrst_bit_timer u_bt (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .run(timing_run),
    .tq_tick(tq_tick),
    .seg_one(bit_configuration_register[`CNRST_TS1_HI:`CNRST_TS1_LO]),
    .seg_two(bit_configuration_register[`CNRST_TS2_HI:`CNRST_TS2_LO]),
    .jump(bit_configuration_register[`CNRST_SJW_HI:`CNRST_SJW_LO]),
    .rx_edge(rx_q & ~can_rx),
    .sample_pulse(sample_pulse),
    .bit_end()
  );
  // ****************
  // Transmit selection
  // ****************
  always @* begin
    sel_found = 1'b0;
    sel_mb = 4'h0;
    sel_id = {IDW{1'b1}};
    // Mailbox 0 never transmits, loop starts at 1
    for (k = 1; k < NMB; k = k + 1) begin
      if (transmit_pending[k] && !mb_dir[k]) begin
        if (tx_order_select) begin
          if (!sel_found) begin
            sel_found = 1'b1;
            sel_mb = k[3:0];
            sel_id = mb_id[k];
          end
        end else if (!sel_found || mb_id[k] < sel_id) begin
          sel_found = 1'b1;
          sel_mb = k[3:0];
          sel_id = mb_id[k];
        end
      end
    end
  end
  // ****************
  // Reset sequencing
  // ****************
  always @* begin
    next_state = state;
    case (state)
      S_CFG: begin
        if (!reset_request_bit) begin
          next_state = S_LEAVE;
        end
      end
      S_LEAVE: begin
        if (dly == `CNRST_RST_DELAY) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (reset_request_bit) begin
          next_state = S_CFG;
        end else if (idle_cnt == `CNRST_IDLE_BITS) begin
          next_state = S_RUN;
        end
      end
      S_RUN: begin
        // Frame in flight must finish first
        if (reset_request_bit && !link_busy && !in_flight) begin
          next_state = S_CFG;
        end
      end
      default: begin
        next_state = S_CFG;
      end
    endcase
  end
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state <= S_CFG;
      dly <= 4'h0;
      idle_cnt <= 4'h0;
      rx_q <= 1'b1;
      reset_state_bit <= 1'b1;
      bus_on <= 1'b0;
    end else begin
      state <= next_state;
      rx_q <= can_rx;
      dly <= (state == S_LEAVE) ? dly + 4'h1 : 4'h0;
      if (state != S_IDLE || (sample_pulse && !can_rx)) begin
        idle_cnt <= 4'h0;
      end else if (sample_pulse) begin
        idle_cnt <= idle_cnt + 4'h1;
      end
      reset_state_bit <= (next_state == S_CFG) || (next_state == S_LEAVE);
      bus_on <= (next_state == S_RUN);
    end
  end
  // ****************
  // Register file
  // ****************
  wire sw_reset_edge = wr && addr == `CNRST_A_CTRL && wdata[`CNRST_CTRL_RSTREQ] &&
    !reset_request_bit;
  wire tx_finish = in_flight && tx_done;
  reg [31:0] next_rdata;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reset_request_bit <= 1'b1;
      tx_order_select <= 1'b0;
      bit_configuration_register <= `CNRST_BITCFG_RST;
      mb_dir <= `CNRST_DIR_RST;
      mb_sel <= 4'h0;
      rdata <= 32'h0000_0000;
    end else begin
      if (lowpwr_req) begin
        reset_request_bit <= 1'b1;
      end else if (wr && addr == `CNRST_A_CTRL) begin
        reset_request_bit <= wdata[`CNRST_CTRL_RSTREQ];
        tx_order_select <= wdata[`CNRST_CTRL_ORDER];
      end
      if (wr && addr == `CNRST_A_BITCFG) begin
        bit_configuration_register <= wdata[15:0];
      end
      // Mailbox 0 direction pinned to receive; untouched by software reset
      if (wr && addr == `CNRST_A_DIR) begin
        mb_dir <= {wdata[NMB-1:1], 1'b1};
      end
      if (wr && addr == `CNRST_A_MBSEL) begin
        mb_sel <= wdata[3:0];
      end
      // Read data stand only in the cycle after the strobe
      rdata <= rd ? next_rdata : 32'h0000_0000;
    end
  end
  // ****************
  // Reset interrupt flag
  // ****************
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reset_interrupt_flag <= 1'b1;
    end else if (lowpwr_req) begin
      // Low-power entry beats a software clear in the same cycle
      reset_interrupt_flag <= 1'b1;
    end else if (wr && addr == `CNRST_A_IFLG && wdata[`CNRST_IFLG_RST]) begin
      reset_interrupt_flag <= 1'b0;
    end
  end
  // ****************
  // Error counters
  // ****************
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      transmit_error_counter <= 8'h00;
      receive_error_counter <= 8'h00;
    end else if (sw_reset_edge || lowpwr_req) begin
      transmit_error_counter <= 8'h00;
      receive_error_counter <= 8'h00;
    end else begin
      // Saturate rather than wrap back to an error-free count
      if (err_tx && transmit_error_counter != 8'hff) begin
        transmit_error_counter <= transmit_error_counter + 8'h01;
      end
      if (err_rx && receive_error_counter != 8'hff) begin
        receive_error_counter <= receive_error_counter + 8'h01;
      end
    end
  end
  // ****************
  // Transmit loader
  // ****************
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      in_flight <= 1'b0;
      tx_load <= 1'b0;
      tx_mb <= 4'h0;
      tx_id <= {IDW{1'b0}};
    end else begin
      tx_load <= 1'b0;
      if (tx_finish) begin
        in_flight <= 1'b0;
      end else if (state == S_RUN && !in_flight && !reset_request_bit && sel_found) begin
        in_flight <= 1'b1;
        tx_load <= 1'b1;
        tx_mb <= sel_mb;
        tx_id <= sel_id;
      end
    end
  end
  // ****************
  // Pending and acknowledge
  // ****************
  wire [NMB-1:0] pend_set = (wr && addr == `CNRST_A_PEND) ?
    {wdata[NMB-1:1], 1'b0} : {NMB{1'b0}};
  wire [NMB-1:0] ack_clr = (wr && addr == `CNRST_A_ACK) ?
    wdata[NMB-1:0] : {NMB{1'b0}};
  generate
    for (g = 0; g < NMB; g = g + 1) begin : g_flag
      always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          transmit_pending[g] <= 1'b0;
          tx_ack[g] <= 1'b0;
        end else begin
          // Software set wins over the clear at the end of a good frame
          if (pend_set[g]) begin
            transmit_pending[g] <= 1'b1;
          end else if (tx_finish && tx_mb == g) begin
            transmit_pending[g] <= 1'b0;
          end
          // Hardware set wins over a software clear of acknowledge
          if (tx_finish && tx_mb == g) begin
            tx_ack[g] <= 1'b1;
          end else if (ack_clr[g]) begin
            tx_ack[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate
  // ****************
  // Read multiplexer
  // ****************
  always @* begin
    next_rdata = 32'h0000_0000;
    case (addr)
      `CNRST_A_CTRL: next_rdata[`CNRST_CTRL_ORDER:0] = {tx_order_select, 1'b0, reset_request_bit};
      `CNRST_A_STAT: next_rdata[`CNRST_STAT_BUSON:`CNRST_STAT_RST] = {bus_on, reset_state_bit};
      `CNRST_A_IFLG: next_rdata[`CNRST_IFLG_RST] = reset_interrupt_flag;
      `CNRST_A_BITCFG: next_rdata[15:0] = bit_configuration_register;
      `CNRST_A_DIR: next_rdata[NMB-1:0] = mb_dir;
      `CNRST_A_PEND: next_rdata[NMB-1:0] = transmit_pending;
      `CNRST_A_ACK: next_rdata[NMB-1:0] = tx_ack;
      `CNRST_A_ERRCNT: next_rdata[15:0] = {receive_error_counter, transmit_error_counter};
      `CNRST_A_MBSEL: next_rdata[3:0] = mb_sel;
      `CNRST_A_MBID: next_rdata[IDW-1:0] = mb_id[mb_sel];
      `CNRST_A_MBDATA: next_rdata = message_payload_bytes[mb_sel][31:0];
      `CNRST_A_TXSTAT: next_rdata[4:0] = {in_flight, tx_mb};
      default: next_rdata = 32'h0000_0000;
    endcase
  end
endmodule

/* File: verilog/cnrst_defs.vh */
`ifndef CNRST_DEFS_VH
`define CNRST_DEFS_VH
// ****************
// Register indices
// ****************
`define CNRST_A_CTRL 4'h0
`define CNRST_A_STAT 4'h1
`define CNRST_A_IFLG 4'h2
`define CNRST_A_BITCFG 4'h3
`define CNRST_A_DIR 4'h4
`define CNRST_A_PEND 4'h5
`define CNRST_A_ACK 4'h6
`define CNRST_A_ERRCNT 4'h7
`define CNRST_A_MBSEL 4'h8
`define CNRST_A_MBID 4'h9
`define CNRST_A_MBDATA 4'ha
`define CNRST_A_TXSTAT 4'hb
// ****************
// Field positions
// ****************
`define CNRST_CTRL_RSTREQ 0
`define CNRST_CTRL_ORDER 2
`define CNRST_STAT_RST 3
`define CNRST_STAT_BUSON 4
`define CNRST_IFLG_RST 0
`define CNRST_BRP_HI 13
`define CNRST_BRP_LO 8
`define CNRST_TS1_HI 3
`define CNRST_TS1_LO 0
`define CNRST_TS2_HI 6
`define CNRST_TS2_LO 4
`define CNRST_SJW_HI 15
`define CNRST_SJW_LO 14
// ****************
// Reset values and counts
// ****************
`define CNRST_DIR_RST 16'h0001
`define CNRST_BITCFG_RST 16'h0000
`define CNRST_IDLE_BITS 4'hb
`define CNRST_RST_DELAY 4'h4
`define CNRST_BIT_BASE 5'h03
`endif

/* File: verilog/cnrst_tq_gen.v */
`timescale 1ns/1ps
`include "cnrst_defs.vh"
// ****************
// Quantum divider
// ****************
module cnrst_tq_gen #(
  parameter PW = 6
) (
  input wire clk_sys,
  input wire nrst,
  input wire run,
  input wire [PW-1:0] prescaler,
  output reg tq_tick
);
  reg [PW:0] cnt;
  wire [PW:0] last = {prescaler, 1'b1};
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt <= {(PW+1){1'b0}};
      tq_tick <= 1'b0;
    end else if (!run) begin
      cnt <= {(PW+1){1'b0}};
      tq_tick <= 1'b0;
    end else if (cnt == last) begin
      // Two clocks times prescaler plus one
      cnt <= {(PW+1){1'b0}};
      tq_tick <= 1'b1;
    end else begin
      cnt <= cnt + {{PW{1'b0}}, 1'b1};
      tq_tick <= 1'b0;
    end
  end
endmodule
